// ===== nff_map.svh
// constants for the nibble fall-through buffer controller
// assumes inclusion by bare name from the package and nff_host
`ifndef NFF_MAP_SVH
`define NFF_MAP_SVH

// word width and depth of the buffer outside
`define NFF_WORD_BITS 4
`define NFF_DEPTH 64
// flip-flops in each pin synchroniser
`define NFF_SYNC_STAGES 2
// width and bit positions of the pin bundle fed through the synchroniser
`define NFF_SYNC_BITS 6
`define NFF_SYNC_SPACE 4
`define NFF_SYNC_VALID 5

`endif

// ===== nff_pkg.sv
// types for the nibble fall-through buffer controller
// assumes nff_map.svh is on the include path
`include "nff_map.svh"

package nff_pkg;

	typedef logic [`NFF_WORD_BITS-1:0] nff_word_t;

	// write side sequence, one-hot
	typedef enum logic [3:0] {
		W_IDLE = 4'h1,
		W_SETUP = 4'h2,
		W_STROBE = 4'h4,
		W_DONE = 4'h8
	} nff_wr_state_t;

	// read side sequence, one-hot
	typedef enum logic [2:0] {
		R_IDLE = 3'h1,
		R_UNLOAD = 3'h2,
		R_DONE = 3'h4
	} nff_rd_state_t;

endpackage

// ===== nff_sync.sv
// multi-bit two-stage synchroniser for pin inputs
// assumes each bit is independently stable long enough to be seen
`timescale 1ns/10ps

module nff_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_q;

	// first stage feeds only the second stage
	always_comb begin
		next_stage1 = d_in;
		next_q = stage1;
	end

	// registers only; reset loads constants
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			stage1 <= '0;
			q_out <= '0;
		end else if (ce_in) begin
			stage1 <= next_stage1;
			q_out <= next_q;
		end
	end

endmodule // nff_sync

// ===== nff_host.sv
// controller driving a 64 x 4 fall-through buffer through its pins
// assumes buffer pins are asynchronous to CLK_IN; user side is on CLK_IN
//
// Function
// - nibble captured while space and load both high; writer holds nibble
// - word held until space and load both low; writer drops load
// - unload while word valid removes the word; word valid drops
// - output word held until valid and unload low, then next word shown
`timescale 1ns/10ps
`include "nff_map.svh"

module nff_host #(
	parameter int WORD_BITS = `NFF_WORD_BITS,
	parameter int DEPTH = `NFF_DEPTH
) (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic CE_IN,
	input wire nff_pkg::nff_word_t WR_DATA_IN,
	input wire logic WR_VALID_IN,
	output logic WR_READY_OUT,
	output nff_pkg::nff_word_t RD_DATA_OUT,
	output logic RD_VALID_OUT,
	input wire logic RD_READY_IN,
	input wire logic SPACE_AVAILABLE_IN,
	output logic LOAD_STROBE_OUT,
	output nff_pkg::nff_word_t WRITE_NIBBLE_OUT,
	input wire logic WORD_VALID_IN,
	input wire nff_pkg::nff_word_t READ_NIBBLE_IN,
	output logic UNLOAD_STROBE_OUT
);
	import nff_pkg::*;

	logic [`NFF_SYNC_BITS-1:0] pins_raw;
	logic [`NFF_SYNC_BITS-1:0] pins_sync;
	logic space_s;
	logic valid_s;
	nff_wr_state_t wr_state;
	nff_wr_state_t next_wr_state;
	nff_word_t nibble;
	nff_word_t next_nibble;
	nff_rd_state_t rd_state;
	nff_rd_state_t next_rd_state;
	logic wr_take;
	logic rd_take;
	logic valid_hold;
	logic next_valid_hold;

	// all buffer pins cross in one bundle; data is only used while valid is steady
	assign pins_raw = {WORD_VALID_IN, SPACE_AVAILABLE_IN, READ_NIBBLE_IN};

	nff_sync #(
		.WIDTH(`NFF_SYNC_BITS)
	) u_pin_sync (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.ce_in(CE_IN),
		.d_in(pins_raw),
		.q_out(pins_sync)
	);

	assign space_s = pins_sync[`NFF_SYNC_SPACE];
	assign valid_s = pins_sync[`NFF_SYNC_VALID];

	// write side handshake, independent of the read side
	assign wr_take = (wr_state == W_IDLE) && space_s && WR_VALID_IN && CE_IN;
	assign WR_READY_OUT = (wr_state == W_IDLE) && space_s && CE_IN;
	assign LOAD_STROBE_OUT = (wr_state == W_STROBE);
	assign WRITE_NIBBLE_OUT = nibble;

	// setup cycle puts the nibble on the pins before load rises
	always_comb begin
		next_wr_state = wr_state;
		next_nibble = nibble;
		unique case (wr_state)
			W_IDLE: begin
				if (wr_take) begin
					next_nibble = WR_DATA_IN; // held through the strobe
					next_wr_state = W_SETUP;
				end
			end
			W_SETUP: begin
				next_wr_state = W_STROBE;
			end
			W_STROBE: begin
				// buffer drops space once it holds the word
				if (!space_s) begin
					next_wr_state = W_DONE;
				end
			end
			W_DONE: begin
				// load low for a cycle; buffer ripples the word on
				next_wr_state = W_IDLE;
			end
		endcase
	end

	// write side registers
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			wr_state <= W_IDLE;
			nibble <= '0;
		end else if (CE_IN) begin
			wr_state <= next_wr_state;
			nibble <= next_nibble;
		end
	end

	// read side: one user word per unload keeps arrival order
	// data pins cross beside valid; one more cycle lets every data bit settle
	assign rd_take = (rd_state == R_IDLE) && valid_s && valid_hold && RD_READY_IN && CE_IN;
	assign RD_VALID_OUT = rd_take;
	assign RD_DATA_OUT = pins_sync[WORD_BITS-1:0];
	assign UNLOAD_STROBE_OUT = (rd_state == R_UNLOAD);

	// unload only after the word is seen; wait for valid to drop, then release
	always_comb begin
		next_rd_state = rd_state;
		next_valid_hold = valid_s;
		unique case (rd_state)
			R_IDLE: begin
				if (rd_take) begin
					next_rd_state = R_UNLOAD;
				end
			end
			R_UNLOAD: begin
				if (!valid_s) begin
					next_rd_state = R_DONE;
				end
			end
			R_DONE: begin
				// valid may stay low while empty; idle just waits
				next_rd_state = R_IDLE;
			end
		endcase
	end

	// read side registers
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			rd_state <= R_IDLE;
			valid_hold <= 1'b0;
		end else if (CE_IN) begin
			rd_state <= next_rd_state;
			valid_hold <= next_valid_hold;
		end
	end

	// checks on the pins and the user outputs this controller drives
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	property p_nib_stable;
		LOAD_STROBE_OUT && $past(LOAD_STROBE_OUT) |-> $stable(WRITE_NIBBLE_OUT);
	endproperty
	a_nib_stable: assert property (p_nib_stable) else $error("nibble moved under load");

	property p_load_after_space;
		$rose(LOAD_STROBE_OUT) |-> $past(space_s, 2);
	endproperty
	a_load_after_space: assert property (p_load_after_space) else $error("load without space");

	property p_load_setup;
		$rose(LOAD_STROBE_OUT) |-> $past(WRITE_NIBBLE_OUT) == WRITE_NIBBLE_OUT;
	endproperty
	a_load_setup: assert property (p_load_setup) else $error("nibble not set up");

	property p_load_drop;
		LOAD_STROBE_OUT && !space_s && CE_IN |=> !LOAD_STROBE_OUT;
	endproperty
	a_load_drop: assert property (p_load_drop) else $error("load not dropped");

	property p_load_gap;
		$fell(LOAD_STROBE_OUT) |-> !LOAD_STROBE_OUT [*2];
	endproperty
	a_load_gap: assert property (p_load_gap) else $error("load rose too soon");

	property p_unload_after_valid;
		$rose(UNLOAD_STROBE_OUT) |-> $past(valid_s) && $past(RD_VALID_OUT);
	endproperty
	a_unload_after_valid: assert property (p_unload_after_valid) else $error("unload w/o valid");

	property p_unload_drop;
		UNLOAD_STROBE_OUT && !valid_s && CE_IN |=> !UNLOAD_STROBE_OUT;
	endproperty
	a_unload_drop: assert property (p_unload_drop) else $error("unload not dropped");

	property p_one_word;
		RD_VALID_OUT |=> !RD_VALID_OUT ##1 !RD_VALID_OUT;
	endproperty
	a_one_word: assert property (p_one_word) else $error("two words per unload");

	c_write: cover property ($fell(LOAD_STROBE_OUT));
	c_read: cover property ($fell(UNLOAD_STROBE_OUT));
	c_both: cover property (LOAD_STROBE_OUT && UNLOAD_STROBE_OUT);
	c_stall: cover property ((valid_s && !RD_READY_IN) [*3]);

endmodule // nff_host

// ===== nff_buf_model.sv
// pin-level model of the 64 x 4 fall-through buffer
// assumes pins only; it keeps no clock of its own
`timescale 1ns/10ps
module nff_buf_model #(
	parameter int DEPTH = 64,
	parameter int DLY = 70
) (
	input wire logic load_in,
	input wire nff_pkg::nff_word_t nibble_in,
	input wire logic unload_in,
	output logic space_out,
	output logic valid_out,
	output nff_pkg::nff_word_t data_out
);
	import nff_pkg::*;
	nff_word_t store[$];
	nff_word_t first;
	int used = 0;
	int queued = 0;
	initial begin
		space_out = 1'b1;
		valid_out = 1'b0;
		data_out = 4'hA;
	end
	// input side; space returns once the word is stored and fewer than DEPTH words are held
	always begin
		wait (load_in && space_out);
		first = nibble_in;
		#DLY space_out = 1'b0;
		wait (!load_in);
		#DLY store.push_back(first);
		used++;
		queued++;
		wait (used < DEPTH);
		space_out = 1'b1;
	end
	// output side; data lines inverted while no word is shown
	always begin
		wait (queued > 0 && !unload_in);
		#DLY data_out = store.pop_front();
		queued--;
		valid_out = 1'b1;
		wait (unload_in);
		#DLY valid_out = 1'b0;
		wait (!unload_in);
		used--;
		#DLY data_out = ~data_out;
	end
endmodule // nff_buf_model

// ===== testbench.sv
// self-checking bench for the buffer controller
// assumes nff_buf_model on the pin side, shrunk to four words
`timescale 1ns/10ps
module testbench;
	import nff_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic wv = 1'b0;
	logic rr = 1'b0;
	nff_word_t wd = 4'h0;
	logic wrdy, rv, ld, ul, sp, ov;
	logic [1:0] seen;
	nff_word_t rd, nib, rn;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	nff_host nff_host_inst (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .WR_DATA_IN(wd),
		.WR_VALID_IN(wv), .WR_READY_OUT(wrdy), .RD_DATA_OUT(rd), .RD_VALID_OUT(rv),
		.RD_READY_IN(rr), .SPACE_AVAILABLE_IN(sp), .LOAD_STROBE_OUT(ld),
		.WRITE_NIBBLE_OUT(nib), .WORD_VALID_IN(ov), .READ_NIBBLE_IN(rn), .UNLOAD_STROBE_OUT(ul));
	nff_buf_model #(.DEPTH(4)) nff_buf_model_inst (.load_in(ld), .nibble_in(nib),
		.unload_in(ul), .space_out(sp), .valid_out(ov), .data_out(rn));
	task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one user write, then the nibble seen on the pins
	task automatic put(input nff_word_t v);
		int n;
		n = 0;
		@(posedge clk);
		wd <= v;
		wv <= 1'b1;
		do @(negedge clk); while (wrdy !== 1'b1 && n++ < 300);
		@(posedge clk);
		wv <= 1'b0;
		do @(negedge clk); while (ld !== 1'b1 && n++ < 600);
		chk("nibble", {1'b1, v}, {ld, nib});
	endtask
	// one user read, then the unload strobe
	task automatic get(input nff_word_t v);
		int n;
		n = 0;
		@(posedge clk);
		rr <= 1'b1;
		do @(negedge clk); while (rv !== 1'b1 && n++ < 300);
		chk("word", {1'b1, v}, {rv, rd});
		@(posedge clk);
		rr <= 1'b0;
		do @(negedge clk); while (ul !== 1'b1 && n++ < 600);
		chk("unload", 5'h01, {4'h0, ul});
	endtask
	// collects any ready or valid seen over n cycles
	task automatic watch(input int n);
		seen = 2'h0;
		repeat (n) begin
			@(negedge clk);
			seen = seen | {rv, wrdy};
		end
	endtask
	task automatic t_full;
		put(4'h1);
		put(4'h2);
		put(4'h3);
		put(4'hF);
		watch(60);
		chk("full", 5'h00, {4'h0, seen[0]});
		get(4'h1);
		put(4'h9);
		get(4'h2);
		get(4'h3);
		get(4'hF);
		get(4'h9);
	endtask
	// empty buffer: no word offered, but space for a write
	task automatic t_empty;
		@(posedge clk);
		rr <= 1'b1;
		watch(60);
		chk("empty", 5'h00, {4'h0, seen[1]});
		chk("space", 5'h01, {4'h0, seen[0]});
		@(posedge clk);
		rr <= 1'b0;
	endtask
	// freeze while a word is shown and space is free, so both flags would rise
	task automatic t_enable;
		put(4'h6);
		repeat (20) @(posedge clk);
		ce <= 1'b0;
		rr <= 1'b1;
		watch(40);
		chk("enable", 5'h00, {3'h0, seen});
		@(posedge clk);
		ce <= 1'b1;
		rr <= 1'b0;
		get(4'h6);
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	// cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		repeat (7) @(posedge clk);
		@(negedge clk);
		chk("reset", 5'h00, {1'b0, wrdy, rv, ld, ul});
		chk("reset nibbles", 5'h00, {1'b0, nib | rd});
		@(posedge clk);
		rstn <= 1'b1;
		t_full();
		t_empty();
		t_enable();
		complete_run;
	end
endmodule // testbench
